/* src/ees_i2c_master.sv */
`timescale 1ns/1ns
// write data buffer with registered full and empty
module ees_fifo #(
   parameter int W = ees_pkg::FIFO_W,
   parameter int DEPTH = ees_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CNW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("ees_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] buf_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [CNW-1:0] cnt_r;
   logic [CNW-1:0] cnt_nxt;
   logic room_r;
   logic empty_r;
   logic push;
   logic pop;

   assign push = in_valid & room_r;
   assign pop = out_ready & ~empty_r;
   assign cnt_nxt = cnt_r + CNW'(push) - CNW'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         buf_r[wp_r] <= in_data;
      end
   end

   // flags come from the next count so they never lag a cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         room_r <= 1'h1;
         empty_r <= 1'h1;
      end else begin
         wp_r <= wp_r + AW'(push);
         rp_r <= rp_r + AW'(pop);
         cnt_r <= cnt_nxt;
         room_r <= (cnt_nxt != CNW'(DEPTH)); // ready leaves straight from a flop
         empty_r <= (cnt_nxt == '0);
      end
   end

   assign in_ready = room_r;
   assign out_valid = ~empty_r;
   assign out_data = buf_r[rp_r];
endmodule

// bus master: random write and random read of the memory
module ees_i2c_master #(
   parameter logic [6:0] DEV_ADDR = ees_pkg::DEV_ADDR_DEF,
   parameter int QTR_CYC = ees_pkg::SCL_QTR_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   ees_if.master BUS,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_READ,
   input wire logic [8:0] CMD_ADDR,
   input wire logic [8:0] CMD_LEN,
   input wire logic WR_VALID,
   output logic WR_READY,
   input wire logic [7:0] WR_DATA,
   output logic RD_VALID,
   output logic [7:0] RD_DATA,
   output logic DONE,
   output logic NACK
);
   if (QTR_CYC < 4 || QTR_CYC > 65535) begin : g_bad_qtr
      $error("ees_i2c_master: QTR_CYC out of range");
   end

   logic f_valid;
   logic f_ready;
   logic f_rdy_r;
   logic [7:0] f_data;
   // stalls at the head while the master waits for the next slot
   ees_fifo #(.W(8), .DEPTH(ees_pkg::FIFO_DEPTH)) u_fifo (
      .clk(CLK_SYS),
      .rst(RESET),
      .in_valid(WR_VALID),
      .in_ready(f_rdy_r),
      .in_data(WR_DATA),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   logic sda1_r;
   logic sda_s;
   // sda comes from the pins
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         sda1_r <= 1'h1;
         sda_s <= 1'h1;
      end else begin
         sda1_r <= BUS.sda;
         sda_s <= sda1_r;
      end
   end

   ees_pkg::ees_mst_st_t state_r;
   logic [15:0] qcnt_r;
   logic [1:0] qtr_r;
   logic [3:0] bit_r;
   logic [2:0] idx_r;
   logic [8:0] left_r;
   logic [8:0] addr_r;
   logic rd_r;
   logic [7:0] sh_r;
   logic ack_r;
   logic scl_oe_n_r;
   logic sda_oe_n_r;
   logic rdy_r;
   logic rdv_r;
   logic [7:0] rdd_r;
   logic done_r;
   logic nack_r;
   logic tick;
   logic last_w;
   logic [7:0] tx_byte_w;

   // quarter-period tick divides CLK_SYS down to scl
   assign tick = (qcnt_r == 16'(QTR_CYC - 1));
   assign last_w = (left_r == 9'h001);
   assign f_ready = (state_r == ees_pkg::M_WAIT);
   assign tx_byte_w = (idx_r == 3'h0) ? {DEV_ADDR, ees_pkg::RW_WRITE} :
                      (idx_r == 3'h1) ? {7'h00, addr_r[8]} :
                      (idx_r == 3'h2) ? addr_r[7:0] :
                      (idx_r == 3'h4) ? {DEV_ADDR, ees_pkg::RW_READ} : sh_r;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         qcnt_r <= 16'h0000;
      end else if (state_r == ees_pkg::M_IDLE || tick) begin
         qcnt_r <= 16'h0000;
      end else begin
         qcnt_r <= qcnt_r + 16'h0001;
      end
   end

   // sequencer: quarters 0 set sda, 1 raise scl, 2 sample, 3 lower scl
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         state_r <= ees_pkg::M_IDLE;
         qtr_r <= 2'h0;
         bit_r <= 4'h0;
         idx_r <= 3'h0;
         left_r <= 9'h000;
         addr_r <= 9'h000;
         rd_r <= 1'h0;
         sh_r <= 8'h00;
         ack_r <= 1'h0;
         scl_oe_n_r <= 1'h1;
         sda_oe_n_r <= 1'h1;
         rdy_r <= 1'h1;
         rdv_r <= 1'h0;
         rdd_r <= 8'h00;
         done_r <= 1'h0;
         nack_r <= 1'h0;
      end else begin
         rdv_r <= 1'h0;
         done_r <= 1'h0;
         case (state_r)
            ees_pkg::M_IDLE: begin
               if (CMD_VALID) begin
                  state_r <= ees_pkg::M_START;
                  rdy_r <= 1'h0;
                  nack_r <= 1'h0;
                  qtr_r <= 2'h0;
                  idx_r <= 3'h0;
                  rd_r <= CMD_READ;
                  addr_r <= CMD_ADDR;
                  left_r <= (CMD_READ && CMD_LEN == 9'h000) ? 9'h001 : CMD_LEN;
               end
            end
            ees_pkg::M_WAIT: begin
               // scl held low until the buffer offers a byte
               if (f_valid) begin
                  sh_r <= f_data;
                  state_r <= ees_pkg::M_TX;
                  bit_r <= 4'h0;
                  qtr_r <= 2'h0;
               end
            end
            ees_pkg::M_START, ees_pkg::M_STOP: begin
               if (tick) begin
                  qtr_r <= qtr_r + 2'h1;
                  case (qtr_r)
                     2'h0: sda_oe_n_r <= (state_r == ees_pkg::M_START);
                     2'h1: scl_oe_n_r <= 1'h1;
                     2'h2: sda_oe_n_r <= (state_r == ees_pkg::M_STOP);
                     default: begin
                        bit_r <= 4'h0;
                        if (state_r == ees_pkg::M_START) begin
                           scl_oe_n_r <= 1'h0;
                           state_r <= ees_pkg::M_TX;
                        end else begin
                           state_r <= ees_pkg::M_IDLE;
                           rdy_r <= 1'h1;
                           done_r <= 1'h1;
                        end
                     end
                  endcase
               end
            end
            default: begin
               if (tick) begin
                  qtr_r <= qtr_r + 2'h1;
                  case (qtr_r)
                     2'h0: begin
                        if (state_r == ees_pkg::M_RX) begin
                           // acknowledge every byte but the last
                           sda_oe_n_r <= (bit_r != 4'h8) | last_w;
                           if (bit_r == 4'h8) begin
                              rdv_r <= 1'h1;
                              rdd_r <= sh_r;
                           end
                        end else if (bit_r == 4'h8) begin
                           sda_oe_n_r <= 1'h1;
                        end else if (bit_r == 4'h0) begin
                           sh_r <= tx_byte_w;
                           sda_oe_n_r <= tx_byte_w[7];
                        end else begin
                           sda_oe_n_r <= sh_r[7];
                        end
                     end
                     2'h1: scl_oe_n_r <= 1'h1;
                     2'h2: begin
                        if (bit_r == 4'h8) begin
                           ack_r <= sda_s;
                        end else if (bit_r != 4'h0 || state_r == ees_pkg::M_RX) begin
                           sh_r <= {sh_r[6:0], sda_s};
                        end else begin
                           sh_r <= {tx_byte_w[6:0], sda_s};
                        end
                     end
                     default: begin
                        scl_oe_n_r <= 1'h0;
                        if (bit_r != 4'h8) begin
                           bit_r <= bit_r + 4'h1;
                        end else if (state_r == ees_pkg::M_RX) begin
                           bit_r <= 4'h0;
                           left_r <= left_r - 9'h001;
                           if (last_w) begin
                              state_r <= ees_pkg::M_STOP;
                           end
                        end else if (ack_r) begin
                           nack_r <= 1'h1;
                           state_r <= ees_pkg::M_STOP;
                        end else begin
                           bit_r <= 4'h0;
                           case (idx_r)
                              3'h0, 3'h1: idx_r <= idx_r + 3'h1;
                              3'h2: begin
                                 idx_r <= rd_r ? 3'h4 : 3'h3;
                                 state_r <= rd_r ? ees_pkg::M_START :
                                            (left_r == 9'h000) ? ees_pkg::M_STOP : ees_pkg::M_WAIT;
                              end
                              3'h3: begin
                                 left_r <= left_r - 9'h001;
                                 state_r <= last_w ? ees_pkg::M_STOP : ees_pkg::M_WAIT;
                              end
                              default: state_r <= ees_pkg::M_RX;
                           endcase
                        end
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // open-drain pins: only the enables move
   assign BUS.m_scl_out = 1'h0;
   assign BUS.m_sda_out = 1'h0;
   assign BUS.m_scl_oe_n = scl_oe_n_r;
   assign BUS.m_sda_oe_n = sda_oe_n_r;
   assign CMD_READY = rdy_r;
   assign WR_READY = f_rdy_r;
   assign RD_VALID = rdv_r;
   assign RD_DATA = rdd_r;
   assign DONE = done_r;
   assign NACK = nack_r;
endmodule

/* src/ees_pkg.sv */
package ees_pkg;
   // storage size and address width
   localparam int MEM_BYTES = 512;
   localparam int ADDR_W = 9;
   // default 7-bit slave address, value chosen freely
   localparam logic [6:0] DEV_ADDR_DEF = 7'h50;
   // read/write code carried after the slave address
   localparam logic RW_WRITE = 1'h0;
   localparam logic RW_READ = 1'h1;
   // input spike rejection: a spike under GLITCH_NS can touch up to ceil(GLITCH_NS/CLK_NS) samples,
   // so one sample more is demanded; pulses somewhat over 50 ns may be dropped as well
   localparam int CLK_NS = 20;
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
   // master bit timing: four quarters per scl period
   localparam int SCL_QTR_CYC = 16;
   // write data buffer
   localparam int FIFO_W = 8;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [2:0] {S_IDLE, S_DEV, S_AH, S_AL, S_WD, S_RD, S_RACK} ees_slv_st_t;
   typedef enum logic [2:0] {M_IDLE, M_START, M_TX, M_RX, M_WAIT, M_STOP} ees_mst_st_t;
endpackage

/* src/ees_if.sv */
`timescale 1ns/1ns
// open-drain bus shared by the master, the memory and outside devices
interface ees_if;
   logic m_scl_out;
   logic m_scl_oe_n;
   logic m_sda_out;
   logic m_sda_oe_n;
   logic s_sda_out;
   logic s_sda_oe_n;
   logic ext_scl_low;
   logic ext_sda_low;
   wire scl;
   wire sda;

   // wired-and with pull-up: any enabled low driver wins
   assign scl = ~((~m_scl_oe_n & ~m_scl_out) | ext_scl_low);
   assign sda = ~((~m_sda_oe_n & ~m_sda_out) | (~s_sda_oe_n & ~s_sda_out) | ext_sda_low);

   modport master (output m_scl_out, output m_scl_oe_n, output m_sda_out, output m_sda_oe_n,
                   input scl, input sda);
   modport slave (output s_sda_out, output s_sda_oe_n, input scl, input sda);
endinterface

/* src/ees_eeprom_slave.sv */
`timescale 1ns/1ns
module ees_eeprom_slave #(
   parameter logic [6:0] DEV_ADDR = ees_pkg::DEV_ADDR_DEF,
   parameter int MEM_BYTES = ees_pkg::MEM_BYTES
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   ees_if.slave BUS,
   output logic STORE_PULSE,
   output logic [8:0] STORE_ADDR,
   output logic [7:0] STORE_DATA,
   output logic SELECTED
);
   localparam int CW = $clog2(ees_pkg::GLITCH_CYC + 1);

   // the array cannot be larger than the 9-bit address pointer can reach
   if (MEM_BYTES > (1 << ees_pkg::ADDR_W) || MEM_BYTES < 2) begin : g_bad_size
      $error("ees_eeprom_slave: MEM_BYTES out of range");
   end

   logic [1:0] raw_w;
   logic [1:0] filt_w;
   assign raw_w = {BUS.scl, BUS.sda};

   // per line: two-stage sync, then a level must hold GLITCH_CYC cycles to count
   for (genvar g = 0; g < 2; g++) begin : g_line
      logic s1_r;
      logic s2_r;
      logic filt_r;
      logic [CW-1:0] cnt_r;
      always_ff @(posedge CLK_SYS or posedge RESET) begin
         if (RESET) begin
            s1_r <= 1'h1;
            s2_r <= 1'h1;
         end else begin
            s1_r <= raw_w[g];
            s2_r <= s1_r;
         end
      end
      // spike shorter than the hold time leaves filt_r untouched
      always_ff @(posedge CLK_SYS or posedge RESET) begin
         if (RESET) begin
            filt_r <= 1'h1;
            cnt_r <= '0;
         end else if (s2_r == filt_r) begin
            cnt_r <= '0;
         end else if (cnt_r == CW'(ees_pkg::GLITCH_CYC - 1)) begin
            filt_r <= s2_r;
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_r + 1'h1;
         end
      end
      assign filt_w[g] = filt_r;
   end

   logic scl_f;
   logic sda_f;
   logic scl_p_r;
   logic sda_p_r;
   assign scl_f = filt_w[1];
   assign sda_f = filt_w[0];

   // previous filtered levels for edge and condition detection
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         scl_p_r <= 1'h1;
         sda_p_r <= 1'h1;
      end else begin
         scl_p_r <= scl_f;
         sda_p_r <= sda_f;
      end
   end

   logic scl_rise_w;
   logic scl_fall_w;
   logic start_w;
   logic stop_w;
   // sda moving while scl stays high marks start or stop
   assign scl_rise_w = scl_f & ~scl_p_r;
   assign scl_fall_w = ~scl_f & scl_p_r;
   assign start_w = scl_f & scl_p_r & sda_p_r & ~sda_f;
   assign stop_w = scl_f & scl_p_r & ~sda_p_r & sda_f;

   ees_pkg::ees_slv_st_t state_r;
   ees_pkg::ees_slv_st_t nxt_w;
   logic [3:0] bit_r;
   logic [7:0] shift_r;
   logic ack_r;
   logic oe_n_r;
   logic [8:0] addr_r;
   logic rw_r;
   logic more_r;
   logic sel_r;
   logic st_pulse_r;
   logic [8:0] st_addr_r;
   logic [7:0] st_data_r;
   logic [7:0] mem [MEM_BYTES];
   logic [7:0] mem_q;
   logic byte_w;
   logic dev_hit;
   logic mem_we;
   logic [8:0] addr_inc;

   // decode of the byte just completed and the following state
   assign byte_w = scl_fall_w & ~ack_r & (bit_r == 4'h8);
   assign dev_hit = (shift_r[7:1] == DEV_ADDR);
   assign mem_we = byte_w & (state_r == ees_pkg::S_WD);
   assign mem_q = mem[addr_r];
   assign addr_inc = addr_r + 9'h001;
   assign nxt_w = (state_r == ees_pkg::S_DEV) ? ees_pkg::S_AH :
                  (state_r == ees_pkg::S_AH) ? ees_pkg::S_AL : ees_pkg::S_WD;

   // storage array, no reset so it maps onto memory
   always_ff @(posedge CLK_SYS) begin
      if (mem_we) begin
         mem[addr_r] <= shift_r;
      end
   end

   // byte framing; the bus is only ever pulled low, never driven high
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         state_r <= ees_pkg::S_IDLE;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         ack_r <= 1'h0;
         oe_n_r <= 1'h1;
         addr_r <= 9'h000;
         rw_r <= 1'h0;
         more_r <= 1'h0;
         sel_r <= 1'h0;
         st_pulse_r <= 1'h0;
         st_addr_r <= 9'h000;
         st_data_r <= 8'h00;
      end else begin
         st_pulse_r <= 1'h0;
         if (start_w) begin
            // repeated start also lands here and keeps the address pointer
            state_r <= ees_pkg::S_DEV;
            bit_r <= 4'h0;
            ack_r <= 1'h0;
            oe_n_r <= 1'h1;
            sel_r <= 1'h0;
         end else if (stop_w || state_r == ees_pkg::S_IDLE) begin
            state_r <= ees_pkg::S_IDLE;
            ack_r <= 1'h0;
            oe_n_r <= 1'h1;
            sel_r <= 1'h0;
         end else if (scl_rise_w) begin
            if (state_r == ees_pkg::S_RACK) begin
               more_r <= ~sda_f; // low means master wants more
            end else if (!ack_r) begin
               shift_r <= {shift_r[6:0], sda_f};
               bit_r <= bit_r + 4'h1;
            end
         end else if (scl_fall_w) begin
            if (ack_r) begin
               // end of our acknowledge slot
               ack_r <= 1'h0;
               bit_r <= 4'h0;
               if (state_r == ees_pkg::S_DEV && rw_r == ees_pkg::RW_READ) begin
                  state_r <= ees_pkg::S_RD;
                  shift_r <= mem_q;
                  oe_n_r <= mem_q[7];
               end else begin
                  state_r <= nxt_w;
                  oe_n_r <= 1'h1;
               end
            end else if (bit_r == 4'h8) begin
               case (state_r)
                  ees_pkg::S_DEV: begin
                     if (dev_hit) begin
                        rw_r <= shift_r[0];
                        ack_r <= 1'h1;
                        oe_n_r <= 1'h0;
                        sel_r <= 1'h1;
                     end else begin
                        state_r <= ees_pkg::S_IDLE;
                     end
                  end
                  ees_pkg::S_AH: begin
                     addr_r[8] <= shift_r[0];
                     ack_r <= 1'h1;
                     oe_n_r <= 1'h0;
                  end
                  ees_pkg::S_AL: begin
                     addr_r[7:0] <= shift_r;
                     ack_r <= 1'h1;
                     oe_n_r <= 1'h0;
                  end
                  ees_pkg::S_WD: begin
                     addr_r <= addr_inc;
                     ack_r <= 1'h1;
                     oe_n_r <= 1'h0;
                     st_pulse_r <= 1'h1;
                     st_addr_r <= addr_r;
                     st_data_r <= shift_r;
                  end
                  ees_pkg::S_RD: begin
                     // release for the master's acknowledge
                     addr_r <= addr_inc;
                     oe_n_r <= 1'h1;
                     state_r <= ees_pkg::S_RACK;
                  end
                  ees_pkg::S_RACK: begin
                     bit_r <= 4'h0;
                     if (more_r) begin
                        state_r <= ees_pkg::S_RD;
                        shift_r <= mem_q;
                        oe_n_r <= mem_q[7];
                     end else begin
                        state_r <= ees_pkg::S_IDLE;
                        sel_r <= 1'h0;
                     end
                  end
                  default: state_r <= ees_pkg::S_IDLE;
               endcase
            end else if (state_r == ees_pkg::S_RD) begin
               oe_n_r <= shift_r[7];
            end
         end
      end
   end

   // open-drain: output level is fixed low, only the enable moves
   assign BUS.s_sda_out = 1'h0;
   assign BUS.s_sda_oe_n = oe_n_r;
   assign STORE_PULSE = st_pulse_r;
   assign STORE_ADDR = st_addr_r;
   assign STORE_DATA = st_data_r;
   assign SELECTED = sel_r;
endmodule

/* dv/ees_sva.sv */
`timescale 1ns/1ns
// link checks beside the interface joining master and memory
module ees_sva (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic scl,
   input wire logic sda,
   input wire logic m_scl_oe_n,
   input wire logic s_sda_oe_n,
   input wire logic STORE_PULSE,
   input wire logic [8:0] STORE_ADDR,
   input wire logic SELECTED
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   logic [8:0] prev_r;
   logic have_r;
   // last stored address, forgotten once the frame ends
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         prev_r <= 9'h000;
         have_r <= 1'h0;
      end else if (STORE_PULSE) begin
         prev_r <= STORE_ADDR;
         have_r <= 1'h1;
      end else if (!SELECTED) begin
         have_r <= 1'h0;
      end
   end
   property p_mem_quiet_high;
      !$stable(s_sda_oe_n) |-> !scl;
   endproperty
   a_mem_quiet_high: assert property (p_mem_quiet_high) else $error("memory moved sda with scl high");
   property p_filter_hold;
      $fell(scl) |=> $stable(s_sda_oe_n) [*4];
   endproperty
   a_filter_hold: assert property (p_filter_hold) else $error("memory answered inside filter delay");
   property p_store_once;
      STORE_PULSE |=> !STORE_PULSE [*8];
   endproperty
   a_store_once: assert property (p_store_once) else $error("store pulses too close");
   property p_store_sel;
      STORE_PULSE |-> SELECTED;
   endproperty
   a_store_sel: assert property (p_store_sel) else $error("store while not selected");
   property p_store_next;
      STORE_PULSE && have_r |-> STORE_ADDR == prev_r + 9'h001;
   endproperty
   a_store_next: assert property (p_store_next) else $error("store address not incremented");
   property p_stop_release;
      scl && $rose(sda) |-> ##[1:12] (s_sda_oe_n && !SELECTED);
   endproperty
   a_stop_release: assert property (p_stop_release) else $error("memory busy after stop");
   property p_scl_low_span;
      $fell(m_scl_oe_n) |=> !m_scl_oe_n [*8];
   endproperty
   a_scl_low_span: assert property (p_scl_low_span) else $error("master scl low too short");
   // main scenarios reached
   c_wrap: cover property (STORE_PULSE && STORE_ADDR == 9'h1FF);
   c_stop: cover property (scl && $rose(sda));
   c_sel: cover property ($rose(SELECTED));
endmodule

/* dv/test_serial_eeprom_i2c_access.sv */
`timescale 1ns/1ns
// master user side driven, memory stores and wire bytes checked against a model
module test_serial_eeprom_i2c_access;
   localparam int MB = ees_pkg::MEM_BYTES;
   logic CLK_SYS, RESET, cmd_valid, cmd_read, wr_valid, glitch_on;
   logic cmd_ready, wr_ready, rd_valid, done, nack, store_pulse, selected;
   logic [8:0] cmd_addr, cmd_len, store_addr, sh;
   logic [7:0] wr_data, rd_data, store_data;
   int n_fail = 0, num_checks = 0, seed = 64651, bit_cnt = 0, e, i, a, n;
   int mem [MB];
   int exp_st [$];
   int exp_rd [$];
   logic [7:0] wire_q [$];
   time t_fall = 0;
   ees_if ees_if_i ();
   ees_eeprom_slave ees_eeprom_slave_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .BUS(ees_if_i.slave),
      .STORE_PULSE(store_pulse), .STORE_ADDR(store_addr), .STORE_DATA(store_data), .SELECTED(selected));
   // short quarters keep the run brief, still above the filter delay
   ees_i2c_master #(.QTR_CYC(8)) ees_i2c_master_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .BUS(ees_if_i.master),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_READ(cmd_read), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len),
      .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data), .RD_VALID(rd_valid), .RD_DATA(rd_data),
      .DONE(done), .NACK(nack));
   ees_sva ees_sva_i (.CLK_SYS(CLK_SYS), .RESET(RESET), .scl(ees_if_i.scl), .sda(ees_if_i.sda),
      .m_scl_oe_n(ees_if_i.m_scl_oe_n), .s_sda_oe_n(ees_if_i.s_sda_oe_n), .STORE_PULSE(store_pulse),
      .STORE_ADDR(store_addr), .SELECTED(selected));
   initial begin
      CLK_SYS = 1'h0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   task automatic stop_test();
      if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t value %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t flag %b want %b", $time, got, exp);
      end
   endtask
   // stores and read bytes against the model, off the launching edge
   always @(negedge CLK_SYS) begin
      if (store_pulse) begin
         chk_flag(exp_st.size() > 0, 1'h1);
         e = exp_st.pop_front();
         chk_val(store_addr, 9'(e >> 8));
         chk_val({1'h0, store_data}, 9'(e & 255));
      end
      if (rd_valid) begin
         chk_flag(exp_rd.size() > 0, 1'h1);
         chk_val({1'h0, rd_data}, 9'(exp_rd.pop_front()));
      end
   end
   // wire sampler; a rise after a short low is a spike, not a bit
   always @(negedge ees_if_i.scl) t_fall = $time;
   always @(posedge ees_if_i.scl) begin
      if ($time - t_fall > 100) begin
         sh = {sh[7:0], ees_if_i.sda};
         bit_cnt++;
         if (bit_cnt % 9 == 0) wire_q.push_back(sh[8:1]);
      end
   end
   always @(negedge ees_if_i.sda) if (ees_if_i.scl) bit_cnt = 0;
   // 40 ns spikes in mid-high, narrower than the filter accepts
   always @(posedge ees_if_i.scl) if (glitch_on && $time - t_fall > 100) begin
      #110 ees_if_i.ext_scl_low = 1'h1;
      #40 ees_if_i.ext_scl_low = 1'h0;
   end
   task automatic push(input logic [7:0] d);
      @(negedge CLK_SYS);
      wr_valid = 1'h1;
      wr_data = d;
      while (wr_ready !== 1'h1) @(negedge CLK_SYS);
      @(negedge CLK_SYS);
      wr_valid = 1'h0;
   endtask
   task automatic cmd(input logic r, input int ad, input int ln);
      @(negedge CLK_SYS);
      cmd_valid = 1'h1;
      cmd_read = r;
      cmd_addr = 9'(ad);
      cmd_len = 9'(ln);
      while (cmd_ready !== 1'h1) @(negedge CLK_SYS);
      @(negedge CLK_SYS);
      cmd_valid = 1'h0;
      while (done !== 1'h1) @(negedge CLK_SYS);
      chk_flag(nack, 1'h0);
   endtask
   // fifo filled first, the rest pushed late and held off by wr_ready until the master pops
   task automatic wr(input int ad, input int ln);
      logic [7:0] d [$];
      int k;
      wire_q.delete();
      for (k = 0; k < ln; k++) begin
         d.push_back(8'($random(seed)));
         mem[(ad + k) % MB] = d[k];
         exp_st.push_back(((ad + k) % MB) * 256 + d[k]);
      end
      for (k = 0; k < ln && k < 8; k++) push(d[k]);
      if (ln >= 8) chk_flag(wr_ready, 1'h0);
      fork
         cmd(1'h0, ad, ln);
         begin
            repeat (400) @(negedge CLK_SYS);
            for (k = 8; k < ln; k++) push(d[k]);
         end
      join
      chk_val({1'h0, wire_q[0]}, {1'h0, ees_pkg::DEV_ADDR_DEF, ees_pkg::RW_WRITE});
      chk_val(9'(wire_q[1][0]), 9'(ad >> 8));
      chk_val({1'h0, wire_q[2]}, 9'(ad & 255));
      for (k = 0; k < ln; k++) chk_val({1'h0, wire_q[3 + k]}, {1'h0, d[k]});
   endtask
   task automatic rd(input int ad, input int ln);
      int k;
      wire_q.delete();
      for (k = 0; k < ln; k++) exp_rd.push_back(mem[(ad + k) % MB]);
      cmd(1'h1, ad, ln);
      chk_val({1'h0, wire_q[3]}, {1'h0, ees_pkg::DEV_ADDR_DEF, ees_pkg::RW_READ});
      chk_flag(exp_rd.size() == 0, 1'h1);
   endtask
   initial begin
      #2_000_000;
      n_fail++;
      stop_test();
   end
   initial begin
      RESET = 1'h1;
      {cmd_valid, cmd_read, wr_valid, glitch_on} = 4'h0;
      {cmd_addr, cmd_len, wr_data} = 26'h000_0000;
      ees_if_i.ext_scl_low = 1'h0;
      ees_if_i.ext_sda_low = 1'h0;
      repeat (5) @(negedge CLK_SYS);
      RESET = 1'h0;
      wr(508, 10);
      rd(508, 10);
      wr(511, 0);
      glitch_on = 1'h1;
      wr(37, 3);
      rd(37, 3);
      glitch_on = 1'h0;
      for (i = 0; i < 3; i++) begin
         a = $random(seed) & 511;
         n = 1 + ($random(seed) & 3);
         wr(a, n);
         rd(a, n);
      end
      // reset in mid-frame must let go of the bus, nothing stored
      for (i = 0; i < 4; i++) push(8'h5A);
      cmd_valid = 1'h1;
      cmd_read = 1'h0;
      cmd_addr = 9'h064;
      cmd_len = 9'h004;
      @(negedge CLK_SYS);
      cmd_valid = 1'h0;
      repeat (300) @(negedge CLK_SYS);
      RESET = 1'h1;
      @(negedge CLK_SYS);
      chk_flag(ees_if_i.scl & ees_if_i.sda, 1'h1);
      RESET = 1'h0;
      rd(37, 2);
      stop_test();
   end
endmodule
